// ---- eecd_top.v ----
// Command decoder and sequencer for one time-triggered edge event generator
//
// Summary of operation
// - Code 0000 replays last N entries M times
// - Repeat count zero loops until new command
// - Code 0001 loops four entries, two counts
// - Single-word toggles: pairs run count times
// - Two-word toggles: each runs twice count
// - Code 0010 captures present time as reference
// - Upper bits pick rise, fall or toggle
// - Lower bits pick absolute, long, short format
// - Absolute format takes five words, fires then
// - Absolute words: seconds high first, ns last
// - Code bits of words two-five ignored
// - Long relative: two words after previous event
// - Second word code bits are ignored
// - Short relative: one word, sixteen-bit delay
// - Sixteen entries of twenty-two bit words
// - Relative edges at least 16ns apart
`timescale 1ns/100ps
`include "eecd_defs.vh"

module eecd_top (
  input  wire        CLK_SYS,
  input  wire        RST,
  input  wire        CMD_WR,
  input  wire [21:0] CMD_WORD,
  input  wire [47:0] TIME_SEC,
  input  wire [29:0] TIME_NS,
  output reg         CMD_FULL,
  output wire        EDGE_OUT,
  output reg         EVENT_DONE
);

  ////////////////////////////////////////////////////////////////////////////
  // States

  localparam [4:0] S_FETCH = 5'h01;
  localparam [4:0] S_DEC   = 5'h02;
  localparam [4:0] S_CALC  = 5'h04;
  localparam [4:0] S_WAIT  = 5'h08;
  localparam [4:0] S_GAP   = 5'h10;

  reg  [4:0]  st_q;
  reg  [4:0]  wp_q;
  reg  [4:0]  rp_q;
  reg  [4:0]  tail_q;
  reg  [2:0]  wc_q;
  reg  [1:0]  act_q;
  reg  [1:0]  fmt_q;
  reg  [1:0]  last_fmt_q;
  reg         stat_q;
  reg  [47:0] sec_q;
  reg  [29:0] ns_q;
  reg  [47:0] ref_sec_q;
  reg  [29:0] ref_ns_q;
  reg  [47:0] tgt_sec_q;
  reg  [29:0] tgt_ns_q;
  reg         arm_q;
  reg         grp_q;
  reg         frac_q;
  reg         phb_q;
  reg         forever_q;
  reg  [11:0] rem_q;
  reg  [4:0]  grp_s_q;
  reg  [4:0]  grp_e_q;
  reg  [4:0]  gw_q;
  reg  [8:0]  ca_q;
  reg  [8:0]  cb_q;
  reg  [3:0]  gap_q;

  wire [21:0] rdata;
  wire        fire;
  wire        wr_ok;
  wire [4:0]  wp_d;
  wire [4:0]  used_d;
  wire        new_data;
  wire [3:0]  w_cmd;
  wire [1:0]  w_act;
  wire [1:0]  w_fmt;
  wire [31:0] gap_ns32;
  wire [31:0] gap_cyc32;
  wire [29:0] delta;
  wire [30:0] sum;
  wire [30:0] sum_m1;
  wire [30:0] sum_m2;
  wire [8:0]  m1_ext;

  ////////////////////////////////////////////////////////////////////////////
  // Command store

  // Consumed slots stay readable until overwritten, which is what replay uses
  assign wr_ok  = CMD_WR && !CMD_FULL;
  assign wp_d   = wr_ok ? wp_q + 5'h01 : wp_q;
  assign used_d = wp_d - tail_q;

  eecd_cmd_mem i_eecd_cmd_mem (
    .clk   (CLK_SYS),
    .rst   (RST),
    .we    (wr_ok),
    .waddr (wp_q[3:0]),
    .wdata (CMD_WORD),
    .raddr (rp_q[3:0]),
    .rdata (rdata)
  );

  eecd_edge_timer i_eecd_edge_timer (
    .clk     (CLK_SYS),
    .rst     (RST),
    .arm     (arm_q),
    .action  (act_q),
    .tgt_sec (tgt_sec_q),
    .tgt_ns  (tgt_ns_q),
    .now_sec (TIME_SEC),
    .now_ns  (TIME_NS),
    .level_q (EDGE_OUT),
    .fire_q  (fire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  assign w_cmd    = rdata[`EECD_CMD_HI:`EECD_CMD_LO];
  assign w_act    = rdata[`EECD_ACT_HI:`EECD_ACT_LO];
  assign w_fmt    = rdata[`EECD_FMT_HI:`EECD_FMT_LO];
  assign new_data = wp_q != gw_q + 5'h01;
  assign gap_ns32 = `EECD_MIN_GAP_NS;
  assign gap_cyc32 = `EECD_MIN_GAP_CYC;

  // Delays below the least spacing are stretched to it
  assign delta  = (ns_q < gap_ns32[29:0]) ? gap_ns32[29:0] : ns_q;
  assign sum    = {1'b0, ref_ns_q} + {1'b0, delta};
  assign sum_m1 = sum - `EECD_NS_PER_SEC;
  assign sum_m2 = sum - `EECD_NS_2SEC;
  // Two-word toggle pairs hold one command, so each pair count doubles
  assign m1_ext = (last_fmt_q == `EECD_FMT_REL32) ? {rdata[15:8], 1'b0}
                                                  : {1'b0, rdata[15:8]};

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  // Step past the current word, looping back where a group ends
  task advance;
    begin
      if (grp_q && (rp_q + 5'h01 == grp_e_q)) begin
        if (!frac_q) begin
          if (forever_q ? new_data : (rem_q == 12'h001)) begin
            grp_q  <= 1'b0;
            rp_q   <= gw_q + 5'h01;
            tail_q <= gw_q + 5'h01;
          end else begin
            if (!forever_q) begin
              rem_q <= rem_q - 12'h001;
            end
            rp_q <= grp_s_q;
          end
        end else if (!phb_q) begin
          if (rem_q > 12'h001) begin
            rem_q <= rem_q - 12'h001;
            rp_q  <= grp_s_q;
          end else begin
            phb_q   <= 1'b1;
            rp_q    <= grp_s_q + 5'h02;
            grp_e_q <= grp_s_q + 5'h04;
            rem_q   <= {3'h0, cb_q};
          end
        end else begin
          if (rem_q > 12'h001) begin
            rem_q <= rem_q - 12'h001;
            rp_q  <= grp_s_q + 5'h02;
          end else if (new_data) begin
            grp_q  <= 1'b0;
            rp_q   <= gw_q + 5'h01;
            tail_q <= gw_q + 5'h01;
          end else begin
            phb_q   <= 1'b0;
            rp_q    <= grp_s_q;
            grp_e_q <= grp_s_q + 5'h02;
            rem_q   <= {3'h0, ca_q};
          end
        end
      end else begin
        rp_q <= rp_q + 5'h01;
        if (!grp_q) begin
          tail_q <= rp_q + 5'h01;
        end
      end
    end
  endtask

  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st_q       <= S_FETCH;
      wp_q       <= 5'h00;
      rp_q       <= 5'h00;
      tail_q     <= 5'h00;
      CMD_FULL   <= 1'b0;
      EVENT_DONE <= 1'b0;
      wc_q       <= 3'h0;
      act_q      <= 2'h0;
      fmt_q      <= 2'h0;
      last_fmt_q <= 2'h0;
      stat_q     <= 1'b0;
      sec_q      <= 48'h000000000000;
      ns_q       <= 30'h00000000;
      ref_sec_q  <= 48'h000000000000;
      ref_ns_q   <= 30'h00000000;
      tgt_sec_q  <= 48'h000000000000;
      tgt_ns_q   <= 30'h00000000;
      arm_q      <= 1'b0;
      grp_q      <= 1'b0;
      frac_q     <= 1'b0;
      phb_q      <= 1'b0;
      forever_q  <= 1'b0;
      rem_q      <= 12'h000;
      grp_s_q    <= 5'h00;
      grp_e_q    <= 5'h00;
      gw_q       <= 5'h00;
      ca_q       <= 9'h000;
      cb_q       <= 9'h000;
      gap_q      <= 4'h0;
    end else begin
      wp_q       <= wp_d;
      CMD_FULL   <= used_d[4];
      EVENT_DONE <= 1'b0;
      arm_q      <= 1'b0;
      case (st_q)
        S_FETCH: begin
          if (rp_q != wp_q) begin
            st_q <= S_DEC;
          end
        end
        S_DEC: begin
          if (wc_q != 3'h0) begin
            // Code bits of continuation words are not looked at
            st_q <= S_FETCH;
            wc_q <= wc_q + 3'h1;
            // The last word is stepped past only once the edge fires,
            // so group counts are not spent twice
            if (fmt_q == `EECD_FMT_REL32) begin
              ns_q[15:0] <= rdata[15:0];
              st_q       <= S_CALC;
              wc_q       <= 3'h0;
            end else begin
              case (wc_q)
                3'h1: begin
                  sec_q[31:16] <= rdata[15:0];
                  advance;
                end
                3'h2: begin
                  sec_q[15:0] <= rdata[15:0];
                  advance;
                end
                3'h3: begin
                  ns_q[29:16] <= rdata[13:0];
                  advance;
                end
                default: begin
                  ns_q[15:0] <= rdata[15:0];
                  st_q       <= S_CALC;
                  wc_q       <= 3'h0;
                end
              endcase
            end
          end else if (w_cmd == `EECD_CMD_REPEAT) begin
            st_q <= S_FETCH;
            if (rdata[3:0] == 4'h0 || grp_q) begin
              advance;
            end else begin
              grp_q     <= 1'b1;
              frac_q    <= 1'b0;
              gw_q      <= rp_q;
              grp_e_q   <= rp_q;
              grp_s_q   <= rp_q - {1'b0, rdata[3:0]};
              rp_q      <= rp_q - {1'b0, rdata[3:0]};
              tail_q    <= rp_q - {1'b0, rdata[3:0]};
              rem_q     <= rdata[15:4];
              forever_q <= rdata[15:4] == 12'h000;
            end
          end else if (w_cmd == `EECD_CMD_FRAC) begin
            st_q <= S_FETCH;
            if (grp_q) begin
              advance;
            end else begin
              grp_q     <= 1'b1;
              frac_q    <= 1'b1;
              phb_q     <= 1'b0;
              forever_q <= 1'b1;
              gw_q      <= rp_q;
              grp_s_q   <= rp_q - 5'h04;
              grp_e_q   <= rp_q - 5'h02;
              rp_q      <= rp_q - 5'h04;
              tail_q    <= rp_q - 5'h04;
              ca_q      <= m1_ext;
              cb_q      <= (last_fmt_q == `EECD_FMT_REL32) ? {rdata[7:0], 1'b0}
                                                           : {1'b0, rdata[7:0]};
              rem_q     <= {3'h0, m1_ext};
            end
          end else if (w_cmd == `EECD_CMD_SETREF) begin
            ref_sec_q <= TIME_SEC;
            ref_ns_q  <= TIME_NS;
            st_q      <= S_FETCH;
            advance;
          end else if (w_act == `EECD_ACT_NONE || w_fmt == `EECD_FMT_NONE) begin
            st_q <= S_FETCH;
            advance;
          end else begin
            act_q      <= w_act;
            fmt_q      <= w_fmt;
            last_fmt_q <= w_fmt;
            stat_q     <= rdata[`EECD_STAT_BIT];
            if (w_fmt == `EECD_FMT_REL16) begin
              ns_q <= {14'h0000, rdata[15:0]};
              st_q <= S_CALC;
            end else begin
              if (w_fmt == `EECD_FMT_ABS) begin
                sec_q[47:32] <= rdata[15:0];
              end else begin
                ns_q <= {rdata[13:0], 16'h0000};
              end
              wc_q <= 3'h1;
              st_q <= S_FETCH;
              advance;
            end
          end
        end
        S_CALC: begin
          arm_q <= 1'b1;
          st_q  <= S_WAIT;
          if (fmt_q == `EECD_FMT_ABS) begin
            tgt_sec_q <= sec_q;
            tgt_ns_q  <= ns_q;
          end else if (sum >= `EECD_NS_2SEC) begin
            tgt_sec_q <= ref_sec_q + 48'h000000000002;
            tgt_ns_q  <= sum_m2[29:0];
          end else if (sum >= `EECD_NS_PER_SEC) begin
            tgt_sec_q <= ref_sec_q + 48'h000000000001;
            tgt_ns_q  <= sum_m1[29:0];
          end else begin
            tgt_sec_q <= ref_sec_q;
            tgt_ns_q  <= sum[29:0];
          end
        end
        S_WAIT: begin
          if (fire) begin
            // Relative edges chain from this event
            ref_sec_q  <= tgt_sec_q;
            ref_ns_q   <= tgt_ns_q;
            EVENT_DONE <= stat_q;
            gap_q      <= gap_cyc32[3:0];
            st_q       <= S_GAP;
            advance;
          end
        end
        S_GAP: begin
          // Holds off the next decode so edges never bunch up
          gap_q <= gap_q - 4'h1;
          if (gap_q <= 4'h1) begin
            st_q <= S_FETCH;
          end
        end
        default: begin
          st_q <= S_FETCH;
        end
      endcase
    end
  end

endmodule

// ---- eecd_defs.vh ----
// Constants shared by the edge event command decoder files
`ifndef EECD_DEFS_VH
`define EECD_DEFS_VH

// Command word layout
`define EECD_WORD_W       22
`define EECD_DEPTH        16
`define EECD_STAT_BIT     21
`define EECD_DIS_BIT      20
`define EECD_CMD_HI       19
`define EECD_CMD_LO       16
`define EECD_ACT_HI       19
`define EECD_ACT_LO       18
`define EECD_FMT_HI       17
`define EECD_FMT_LO       16

// Command codes and fields
`define EECD_CMD_REPEAT   4'h0
`define EECD_CMD_FRAC     4'h1
`define EECD_CMD_SETREF   4'h2
`define EECD_ACT_NONE     2'h0
`define EECD_ACT_RISE     2'h1
`define EECD_ACT_FALL     2'h2
`define EECD_ACT_TOGGLE   2'h3
`define EECD_FMT_NONE     2'h0
`define EECD_FMT_ABS      2'h1
`define EECD_FMT_REL32    2'h2
`define EECD_FMT_REL16    2'h3

// Time arithmetic
`define EECD_NS_PER_SEC   31'h3B9ACA00
`define EECD_NS_2SEC      31'h77359400

// Timing
`define EECD_CLK_PERIOD_NS 25
`define EECD_MIN_GAP_NS    16
`define EECD_MIN_GAP_CYC   ((`EECD_MIN_GAP_NS + `EECD_CLK_PERIOD_NS - 1) / `EECD_CLK_PERIOD_NS)

`endif

// ---- eecd_cmd_mem.v ----
// Sixteen-entry command word store with registered read data
`timescale 1ns/100ps
`include "eecd_defs.vh"

module eecd_cmd_mem (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    we,
  input  wire [3:0]              waddr,
  input  wire [`EECD_WORD_W-1:0] wdata,
  input  wire [3:0]              raddr,
  output reg  [`EECD_WORD_W-1:0] rdata
);

  reg [`EECD_WORD_W-1:0] mem [0:`EECD_DEPTH-1];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 22'h000000;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// ---- eecd_edge_timer.v ----
// Armed edge placement against the time engine's present time
`timescale 1ns/100ps
`include "eecd_defs.vh"

module eecd_edge_timer (
  input  wire        clk,
  input  wire        rst,
  input  wire        arm,
  input  wire [1:0]  action,
  input  wire [47:0] tgt_sec,
  input  wire [29:0] tgt_ns,
  input  wire [47:0] now_sec,
  input  wire [29:0] now_ns,
  output reg         level_q,
  output reg         fire_q
);

  reg        armed_q;
  reg [1:0]  act_q;
  wire       due;

  // Seconds above nanoseconds makes one plain magnitude compare
  assign due = {now_sec, now_ns} >= {tgt_sec, tgt_ns};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      armed_q <= 1'b0;
      act_q   <= 2'h0;
      level_q <= 1'b0;
      fire_q  <= 1'b0;
    end else begin
      fire_q <= 1'b0;
      if (arm) begin
        armed_q <= 1'b1;
        act_q   <= action;
      end else if (armed_q && due) begin
        armed_q <= 1'b0;
        fire_q  <= 1'b1;
        case (act_q)
          `EECD_ACT_RISE:   level_q <= 1'b1;
          `EECD_ACT_FALL:   level_q <= 1'b0;
          `EECD_ACT_TOGGLE: level_q <= ~level_q;
          default:          level_q <= level_q;
        endcase
      end
    end
  end

endmodule

// ---- eecd_top_assertions.sv ----
// Port-level assertion checker for the edge event command decoder
`timescale 1ns/100ps

module eecd_top_checker (
  input wire        CLK_SYS,
  input wire        RST,
  input wire        CMD_WR,
  input wire [21:0] CMD_WORD,
  input wire [47:0] TIME_SEC,
  input wire [29:0] TIME_NS,
  input wire        CMD_FULL,
  input wire        EDGE_OUT,
  input wire        EVENT_DONE
);
  logic [4:0] wr_cnt_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Saturating count of accepted words; saturation keeps the full check valid
  always @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      wr_cnt_q <= 5'h00;
    end else if (CMD_WR && !CMD_FULL && wr_cnt_q != 5'h1F) begin
      wr_cnt_q <= wr_cnt_q + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  sequence edge_s;
    $changed(EDGE_OUT);
  endsequence

  sequence done_quiet_s;
    !EVENT_DONE [*2];
  endsequence

  a_reset_quiet_outputs: assert property (disable iff (1'b0)
    RST |-> !CMD_FULL && !EDGE_OUT && !EVENT_DONE) else $error("outputs active in reset");
  a_full_rise_cause: assert property ($rose(CMD_FULL) |-> $past(CMD_WR))
    else $error("full rose without a write");
  a_full_needs_sixteen: assert property (CMD_FULL |-> wr_cnt_q >= 5'h10)
    else $error("full before sixteen words");
  a_edge_min_spacing: assert property (edge_s |=> !$changed(EDGE_OUT))
    else $error("edges on adjacent cycles");
  a_done_single_pulse: assert property (EVENT_DONE |=> done_quiet_s)
    else $error("completion pulse too long");
  a_edge_after_command: assert property (edge_s |-> wr_cnt_q != 5'h00)
    else $error("edge without any command");
  a_done_after_command: assert property (EVENT_DONE |-> wr_cnt_q != 5'h00)
    else $error("completion without any command");
  a_idle_output_low: assert property (wr_cnt_q == 5'h00 |-> !EDGE_OUT)
    else $error("output high before any command");
endmodule

bind eecd_top eecd_top_checker i_eecd_top_checker (
  .CLK_SYS    (CLK_SYS),
  .RST        (RST),
  .CMD_WR     (CMD_WR),
  .CMD_WORD   (CMD_WORD),
  .TIME_SEC   (TIME_SEC),
  .TIME_NS    (TIME_NS),
  .CMD_FULL   (CMD_FULL),
  .EDGE_OUT   (EDGE_OUT),
  .EVENT_DONE (EVENT_DONE)
);

// ---- eecd_top_tb_top.sv ----
// Self-checking testbench for the edge event command decoder
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin num_errors++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end

module eecd_top_tb_top;
  reg          clk_sys = 1'b0;
  reg          rst = 1'b1;
  reg          cmd_wr = 1'b0;
  reg  [21:0]  cmd_word = 22'h000000;
  reg  [47:0]  time_sec = 48'h0002_0002_0002;
  reg  [29:0]  time_ns = 30'h0;
  wire         cmd_full;
  wire         edge_out;
  wire         event_done;
  int          num_errors = 0;
  int          samples_checked = 0;
  int          done_cnt = 0;
  logic [29:0] stamps[$];
  logic        last_lvl = 1'b0;

  eecd_top i_eecd_top (
    .CLK_SYS    (clk_sys),
    .RST        (rst),
    .CMD_WR     (cmd_wr),
    .CMD_WORD   (cmd_word),
    .TIME_SEC   (time_sec),
    .TIME_NS    (time_ns),
    .CMD_FULL   (cmd_full),
    .EDGE_OUT   (edge_out),
    .EVENT_DONE (event_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Time engine advances by one clock period per cycle
  always @(negedge clk_sys) time_ns <= time_ns + 30'h19;

  // Edge stamps hold the time value that was sampled at the changing edge
  always @(posedge clk_sys) begin
    #1;
    if (edge_out !== last_lvl) begin
      stamps.push_back(time_ns);
      last_lvl = edge_out;
    end
    if (event_done === 1'b1) done_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task put(input [21:0] w);
    @(negedge clk_sys);
    cmd_wr = 1'b1;
    cmd_word = w;
    @(negedge clk_sys);
    cmd_wr = 1'b0;
  endtask

  task wait_edges(input int n);
    for (int i = 0; i < 4000 && stamps.size() < n; i++) @(negedge clk_sys);
    `CHK(stamps.size() >= n, 1'b1)
  endtask

  function bit near(input [29:0] s, input [29:0] t, input [29:0] slack);
    near = (s >= t) && (s <= t + slack);
  endfunction

  task t_abs_rel;
    logic [29:0] t0;
    stamps.delete();
    t0 = time_ns + 30'd3000;
    put(22'h250002);
    put(22'h0F0002);
    put(22'h030002);
    put({6'h08, 2'b00, t0[29:16]});
    put({6'h0C, t0[15:0]});
    put({6'h0B, 16'd400});
    put({6'h0E, 16'h0000});
    put({6'h01, 16'd500});
    wait_edges(3);
    `CHK(near(stamps[0], t0, 30'd100), 1'b1)
    `CHK(near(stamps[1], t0 + 30'd400, 30'd100), 1'b1)
    `CHK(near(stamps[2], t0 + 30'd900, 30'd100), 1'b1)
    `CHK(edge_out, 1'b1)
    `CHK(done_cnt, 1)
  endtask

  task t_setref;
    logic [29:0] w;
    stamps.delete();
    put(22'h02ABCD);
    w = time_ns;
    put({6'h0B, 16'd600});
    wait_edges(1);
    `CHK(near(stamps[0], w + 30'd600, 30'd300), 1'b1)
    `CHK(edge_out, 1'b0)
  endtask

  task t_repeat;
    int sz;
    stamps.delete();
    put({6'h0F, 16'd300});
    put({6'h0F, 16'd500});
    put(22'h000002);
    wait_edges(7);
    for (int i = 1; i < 7; i++) `CHK(stamps[i] - stamps[i-1], (i % 2) ? 30'd500 : 30'd300)
    put(22'h020000);
    repeat (80) @(negedge clk_sys);
    sz = stamps.size();
    repeat (80) @(negedge clk_sys);
    `CHK(stamps.size(), sz)
  endtask

  task t_frac;
    int s;
    stamps.delete();
    // Fresh reference so the chain does not start in the past
    put(22'h020000);
    put({6'h0F, 16'd300});
    put({6'h0F, 16'd300});
    put({6'h0F, 16'd400});
    put({6'h0F, 16'd400});
    put(22'h010102);
    wait_edges(17);
    s = 2;
    while (s < 9 && !(stamps[s] - stamps[s-1] == 30'd300 &&
                      stamps[s-1] - stamps[s-2] == 30'd400)) s++;
    for (int k = 0; k < 8; k++) `CHK(stamps[s+k] - stamps[s+k-1], (k < 2 || k > 5) ? 30'd300 : 30'd400)
    put(22'h020000);
    repeat (200) @(negedge clk_sys);
  endtask

  task t_undef;
    logic lvl;
    stamps.delete();
    lvl = edge_out;
    put(22'h030000);
    put(22'h040000);
    put(22'h080000);
    put(22'h0C0000);
    put({6'h0F, 16'd300});
    repeat (60) @(negedge clk_sys);
    `CHK(stamps.size(), 1)
    `CHK(edge_out, ~lvl)
  endtask

  task t_full;
    int n;
    stamps.delete();
    put(22'h050002);
    put(22'h050003);
    put(22'h050001);
    put(22'h050000);
    put(22'h050000);
    for (n = 0; n < 30 && cmd_full !== 1'b1; n++) put(22'h030000);
    `CHK(cmd_full, 1'b1)
    `CHK(stamps.size(), 0)
    @(negedge clk_sys);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    `CHK(cmd_full, 1'b0)
    `CHK(edge_out, 1'b0)
    rst = 1'b0;
  endtask

  task print_verdict;
    $display("Checks %0d, errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors++;
    print_verdict;
  end

  initial begin
    repeat (8) @(negedge clk_sys);
    `CHK(edge_out, 1'b0)
    rst = 1'b0;
    t_abs_rel;
    t_setref;
    t_repeat;
    t_frac;
    t_undef;
    t_full;
    print_verdict;
  end
endmodule
